// ==== fpr_pkg.sv ====
// Package for the fan ramp limiter: register map, field layout, ramp timing and bus carriers.
// Assumes a 25 MHz device clock and an AXI4-Lite master with 32-bit data.
package fpr_pkg;

    localparam int ADDR_W = 12;
    localparam int DUTY_W = 8;
    localparam int CNT_W = 18;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_RAMP_CFG = 8'h10;
    localparam logic [7:0] IDX_LOCK_CFG = 8'h40;
    localparam logic [7:0] IDX_RAMP_RATE_REMOTE1_A = 8'h62;
    localparam logic [7:0] IDX_RAMP_RATE_REMOTE1_B = 8'h63;
    localparam logic [7:0] IDX_DUTY_STAT = 8'h70;

    localparam logic [7:0] RST_RAMP_RATE_REMOTE1_A = 8'h00;
    localparam logic [7:0] RST_RAMP_RATE_REMOTE1_B = 8'h00;
    localparam logic [7:0] RST_RAMP_CFG = 8'h00;

    // Field positions
    localparam int A_RATE_LSB = 0;
    localparam int A_SMOOTH_BIT = 3;
    localparam int A_SYNC_BIT = 4;
    localparam int A_FLOOR_LSB = 5;
    localparam int B_LOCAL_LSB = 0;
    localparam int B_LOCAL_EN_BIT = 3;
    localparam int B_REM2_LSB = 4;
    localparam int B_REM2_EN_BIT = 7;
    localparam int CFG_DIV4_LSB = 0;
    localparam int CFG_SLOW_BIT = 7;
    localparam int LOCK_BIT = 0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing: ramp tick of 10 us, sweep times in tenths of a second
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS = 10000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SWEEP_UNIT_NS = 100000000;
    localparam int TICKS_PER_UNIT = SWEEP_UNIT_NS / TICK_NS;
    localparam int FULL_STEPS = 255;
    localparam int DIV4_FACTOR = 4;
    // Codes 0..7 are step multipliers 1,2,3,5,8,12,24,48
    localparam int SWEEP_FAST [8] = '{375, 188, 125, 75, 47, 31, 16, 8};
    localparam int SWEEP_SLOW [8] = '{522, 261, 174, 104, 65, 44, 22, 11};

    typedef enum logic [1:0] {
        CH_REMOTE1 = 2'b00,
        CH_LOCAL = 2'b01,
        CH_REMOTE2 = 2'b10,
        CH_NONE = 2'b11
    } fpr_chan_t;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } fpr_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fpr_axil_rsp_t;

    typedef struct packed {
        logic auto_mode;
        logic below_floor;
        fpr_chan_t chan;
        logic [DUTY_W-1:0] min_duty;
        logic [DUTY_W-1:0] duty_req;
    } fpr_fan_in_t;

    // Tick interval per one-LSB duty step
    function automatic logic [CNT_W-1:0] fpr_step_ticks(input logic [2:0] code,
                                                        input logic slow, input logic div4);
        int t;
        t = slow ? SWEEP_SLOW[code] : SWEEP_FAST[code];
        t = t * TICKS_PER_UNIT / FULL_STEPS;
        if (div4) begin
            t = t * DIV4_FACTOR;
        end
        return t[CNT_W-1:0];
    endfunction

endpackage

// ==== fpr_ramp_chan.sv ====
// One duty ramp: walks duty toward target one step per interval, or follows at once.
// Assumes tick is a one-cycle pulse and interval is at least one tick.
module fpr_ramp_chan #(
    parameter int DW = 8,
    parameter int CW = 18
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic [CW-1:0] interval,
    input wire logic smooth_en,
    input wire logic [DW-1:0] target,
    output logic [DW-1:0] duty_r
);
    logic [CW-1:0] cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_r <= '0;
            cnt_r <= '0;
        end else if (!smooth_en) begin
            duty_r <= target;
            cnt_r <= '0;
        end else if (duty_r == target) begin
            cnt_r <= '0;
        end else if (tick) begin
            if (cnt_r + 1'b1 >= interval) begin
                cnt_r <= '0;
                // One LSB per interval caps the slope
                duty_r <= (target > duty_r) ? duty_r + 1'b1 : duty_r - 1'b1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    a_bypass_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        !smooth_en |=> duty_r == $past(target))
        else $error("duty did not follow target with smoothing off");

    a_step_single_lsb: assert property (@(posedge aclk) disable iff (!aresetn)
        smooth_en && $past(smooth_en) && $changed(duty_r) |->
            (duty_r == $past(duty_r) + 1'b1) || (duty_r == $past(duty_r) - 1'b1))
        else $error("smoothed duty moved more than one step");

    a_step_on_tick: assert property (@(posedge aclk) disable iff (!aresetn)
        smooth_en && !tick |=> duty_r == $past(duty_r))
        else $error("smoothed duty moved without a tick");

endmodule // fpr_ramp_chan

// ==== fpr_pwm_out.sv ====
// Fixed-period PWM pin generator: high for duty out of 255 counts.
// Assumes duty is steady enough that glitches between periods do not matter.
module fpr_pwm_out #(
    parameter int DW = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [DW-1:0] duty,
    output logic pin_r
);
    logic [DW-1:0] phase_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= '0;
        end else if (phase_r == {DW{1'b1}} - 1'b1) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_r + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= phase_r < duty;
        end
    end

    a_zero_duty_low: assert property (@(posedge aclk) disable iff (!aresetn)
        duty == '0 |=> !pin_r)
        else $error("pin high at zero duty");

endmodule // fpr_pwm_out

// ==== fpr_ramp_limiter.sv ====
// Fan duty ramp limiter with acoustic control registers behind an AXI4-Lite slave.
// Assumes duty requests, floor flags and channel choice come from the fan control loop.
//
// Added by the designer: the AXI4-Lite register port.
module fpr_ramp_limiter #(
    parameter int TICK_LEN = fpr_pkg::TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire fpr_pkg::fpr_axil_req_t axi_req,
    output fpr_pkg::fpr_axil_rsp_t axi_rsp,
    input wire fpr_pkg::fpr_fan_in_t [2:0] fan_in,
    output logic fan_drive_out_a,
    output logic fan_drive_out_b,
    output logic fan_drive_out_c,
    output logic speed_sense_sync_b,
    output logic speed_sense_sync_c,
    output logic speed_sense_sync_d
);
    import fpr_pkg::*;

    logic [7:0] acoustic_ramp_ctrl_a_r;
    logic [7:0] acoustic_ramp_ctrl_b_r;
    logic [7:0] ramp_cfg_r;
    logic lock_r;

    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic wstrb0_r;

    logic [15:0] tick_cnt_r;
    logic tick_r;
    logic [2:0] pin_r;
    logic sync_b_r;
    logic [DUTY_W-1:0] duty [3];

    logic do_wr;
    logic [7:0] wr_idx;
    logic wr_hit;
    logic wr_byte;
    logic [7:0] rd_idx;
    logic rd_hit;
    logic [31:0] rd_word;

    // Write channel: address and data captured in either order
    assign do_wr = !awready_r && !wready_r && !bvalid_r;
    assign wr_idx = awaddr_r[9:2];
    assign wr_byte = do_wr && wstrb0_r && wr_hit;

    always_comb begin
        wr_hit = awaddr_r[ADDR_W-1:10] == '0;
        case (wr_idx)
            IDX_RAMP_CFG, IDX_LOCK_CFG, IDX_RAMP_RATE_REMOTE1_A, IDX_RAMP_RATE_REMOTE1_B, IDX_DUTY_STAT: ;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            awaddr_r <= '0;
        end else if (axi_req.awvalid && awready_r) begin
            awready_r <= 1'b0;
            awaddr_r <= axi_req.awaddr;
        end else if (bvalid_r && axi_req.bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            wdata_r <= '0;
            wstrb0_r <= 1'b0;
        end else if (axi_req.wvalid && wready_r) begin
            wready_r <= 1'b0;
            wdata_r <= axi_req.wdata;
            wstrb0_r <= axi_req.wstrb[0];
        end else if (bvalid_r && axi_req.bready) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && axi_req.bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Acoustic registers; a locked write still answers OKAY but changes nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acoustic_ramp_ctrl_a_r <= RST_RAMP_RATE_REMOTE1_A;
        end else if (wr_byte && wr_idx == IDX_RAMP_RATE_REMOTE1_A && !lock_r) begin
            acoustic_ramp_ctrl_a_r <= wdata_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acoustic_ramp_ctrl_b_r <= RST_RAMP_RATE_REMOTE1_B;
        end else if (wr_byte && wr_idx == IDX_RAMP_RATE_REMOTE1_B && !lock_r) begin
            acoustic_ramp_ctrl_b_r <= wdata_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ramp_cfg_r <= RST_RAMP_CFG;
        end else if (wr_byte && wr_idx == IDX_RAMP_CFG) begin
            ramp_cfg_r <= wdata_r[7:0];
        end
    end

    // Lock is set-only; only reset releases it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_r <= 1'b0;
        end else if (wr_byte && wr_idx == IDX_LOCK_CFG && wdata_r[LOCK_BIT]) begin
            lock_r <= 1'b1;
        end
    end

    // Read channel: one-cycle latency
    assign rd_idx = axi_req.araddr[9:2];

    always_comb begin
        rd_hit = axi_req.araddr[ADDR_W-1:10] == '0;
        rd_word = '0;
        case (rd_idx)
            IDX_RAMP_CFG: rd_word[7:0] = ramp_cfg_r;
            IDX_LOCK_CFG: rd_word[LOCK_BIT] = lock_r;
            IDX_RAMP_RATE_REMOTE1_A: rd_word[7:0] = acoustic_ramp_ctrl_a_r;
            IDX_RAMP_RATE_REMOTE1_B: rd_word[7:0] = acoustic_ramp_ctrl_b_r;
            IDX_DUTY_STAT: rd_word[23:0] = {duty[2], duty[1], duty[0]};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (axi_req.arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_hit ? rd_word : '0;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && axi_req.rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    assign axi_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
                       bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
                       rdata: rdata_r, rresp: rresp_r};

    // Shared ramp tick; coarse tick keeps the step counters narrow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == 16'(TICK_LEN - 1)) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // Tach sync: c and d are always held high, b only when asked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_b_r <= 1'b0;
        end else begin
            sync_b_r <= acoustic_ramp_ctrl_a_r[A_SYNC_BIT];
        end
    end

    assign speed_sense_sync_b = sync_b_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed_sense_sync_c <= 1'b1;
            speed_sense_sync_d <= 1'b1;
        end else begin
            speed_sense_sync_c <= 1'b1;
            speed_sense_sync_d <= 1'b1;
        end
    end

    // Per-output path: channel decode, floor choice, ramp, pin
    for (genvar i = 0; i < 3; i++) begin : g_out
        logic [2:0] code;
        logic smooth;
        logic [CNT_W-1:0] interval_r;
        logic [DUTY_W-1:0] target_r;

        always_comb begin
            case (fan_in[i].chan)
                CH_REMOTE1: begin
                    code = acoustic_ramp_ctrl_a_r[A_RATE_LSB +: 3];
                    smooth = acoustic_ramp_ctrl_a_r[A_SMOOTH_BIT];
                end
                CH_LOCAL: begin
                    code = acoustic_ramp_ctrl_b_r[B_LOCAL_LSB +: 3];
                    smooth = acoustic_ramp_ctrl_b_r[B_LOCAL_EN_BIT];
                end
                CH_REMOTE2: begin
                    code = acoustic_ramp_ctrl_b_r[B_REM2_LSB +: 3];
                    smooth = acoustic_ramp_ctrl_b_r[B_REM2_EN_BIT];
                end
                default: begin
                    code = 3'h0;
                    smooth = 1'b0;
                end
            endcase
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                interval_r <= '0;
            end else begin
                // Same table for all three outputs; slow and divide bits apply on top
                interval_r <= fpr_step_ticks(code, ramp_cfg_r[CFG_SLOW_BIT],
                                             ramp_cfg_r[CFG_DIV4_LSB + i]);
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                target_r <= '0;
            end else if (fan_in[i].auto_mode && fan_in[i].below_floor) begin
                target_r <= acoustic_ramp_ctrl_a_r[A_FLOOR_LSB + i] ?
                            fan_in[i].min_duty : '0;
            end else begin
                target_r <= fan_in[i].duty_req;
            end
        end

        fpr_ramp_chan #(.DW(DUTY_W), .CW(CNT_W)) u_ramp (
            .aclk(aclk),
            .aresetn(aresetn),
            .tick(tick_r),
            .interval(interval_r),
            .smooth_en(smooth),
            .target(target_r),
            .duty_r(duty[i])
        );

        fpr_pwm_out #(.DW(DUTY_W)) u_pwm (
            .aclk(aclk),
            .aresetn(aresetn),
            .duty(duty[i]),
            .pin_r(pin_r[i])
        );

        a_floor_target: assert property (@(posedge aclk) disable iff (!aresetn)
            fan_in[i].auto_mode && fan_in[i].below_floor |=>
                target_r == ($past(acoustic_ramp_ctrl_a_r[A_FLOOR_LSB + i]) ?
                             $past(fan_in[i].min_duty) : 8'h00))
            else $error("below-floor target wrong");

        a_interval_table: assert property (@(posedge aclk) disable iff (!aresetn)
            $stable(code) && $stable(ramp_cfg_r) && code == 3'h7 &&
                !ramp_cfg_r[CFG_SLOW_BIT] && !ramp_cfg_r[CFG_DIV4_LSB + i] |=>
                interval_r == 18'(8 * TICKS_PER_UNIT / FULL_STEPS))
            else $error("fastest ramp interval wrong");
    end

    assign fan_drive_out_a = pin_r[0];
    assign fan_drive_out_b = pin_r[1];
    assign fan_drive_out_c = pin_r[2];

    sequence s_aw_taken;
        axi_req.awvalid && awready_r;
    endsequence

    sequence s_w_taken;
        axi_req.wvalid && wready_r;
    endsequence

    a_write_answered: assert property (@(posedge aclk) disable iff (!aresetn)
        s_aw_taken and s_w_taken |=> ##1 bvalid_r)
        else $error("write response not raised two cycles after both channels");

    a_read_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        axi_req.arvalid && arready_r |=> rvalid_r && !arready_r)
        else $error("read data not one cycle after address");

    a_lock_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_r |=> $stable(acoustic_ramp_ctrl_a_r) && $stable(acoustic_ramp_ctrl_b_r))
        else $error("acoustic register changed while locked");

    a_reset_zero: assert property (@(posedge aclk)
        !aresetn |=> acoustic_ramp_ctrl_a_r == 8'h00 && acoustic_ramp_ctrl_b_r == 8'h00)
        else $error("acoustic registers not zero after reset");

    a_sync_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> speed_sense_sync_b == $past(acoustic_ramp_ctrl_a_r[A_SYNC_BIT])
                 && speed_sense_sync_c && speed_sense_sync_d)
        else $error("tach sync selection wrong");

endmodule // fpr_ramp_limiter

// ==== fpr_fan_model.sv ====
// Fan model: counts the high cycles of each PWM output over every 255-cycle frame.
// Assumes each fan sees a steady duty across a whole frame before its count is read.
module fpr_fan_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] pins,
    output logic [2:0][7:0] meas_r
);
    logic [7:0] frame_r;
    logic [2:0][7:0] acc_r;

    // Free-running frame, so any phase of the PWM period is measured alike
    always_ff @(posedge aclk) begin
        if (!aresetn || frame_r == 8'hfe) begin
            frame_r <= 8'h00;
        end else begin
            frame_r <= frame_r + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < 3; i++) begin
            if (!aresetn) begin
                acc_r[i] <= 8'h00;
                meas_r[i] <= 8'h00;
            end else if (frame_r == 8'hfe) begin
                meas_r[i] <= acc_r[i] + 8'(pins[i]);
                acc_r[i] <= 8'h00;
            end else begin
                acc_r[i] <= acc_r[i] + 8'(pins[i]);
            end
        end
    end
endmodule // fpr_fan_model

// ==== tb.sv ====
// Testbench for the fan ramp limiter: AXI4-Lite master, fan loop stimulus, fan model.
// Assumes the design's package and a ramp tick shortened to two cycles.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fpr_pkg::*;
    // Two-cycle tick leaves one idle cycle between ticks, so stepping off-tick can show
    localparam int TL = 2;
    // Code a, code b, code c, slow bit, divide bits, wait cycles
    localparam int RT [4][6] = '{'{7, 6, 5, 0, 1, 4000}, '{4, 3, 7, 0, 4, 8000},
                                 '{7, 7, 7, 1, 2, 4000}, '{2, 1, 0, 0, 0, 16000}};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    fpr_axil_req_t req = '0;
    fpr_axil_rsp_t rsp;
    fpr_fan_in_t [2:0] fan = '0;
    logic fa, fb, fc, sb, sc, sd;
    logic [2:0][7:0] meas;
    int err_total = 0;
    int compares = 0;
    logic [31:0] seed = 32'hc66a;
    logic [1:0] resp;
    logic [31:0] rd;
    int fast_t [8] = '{375, 188, 125, 75, 47, 31, 16, 8};
    int slow_t [8] = '{522, 261, 174, 104, 65, 44, 22, 11};

    fpr_ramp_limiter #(.TICK_LEN(TL)) dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
        .axi_rsp(rsp), .fan_in(fan), .fan_drive_out_a(fa), .fan_drive_out_b(fb),
        .fan_drive_out_c(fc), .speed_sense_sync_b(sb), .speed_sense_sync_c(sc),
        .speed_sense_sync_d(sd));
    fpr_fan_model fan_u (.aclk(aclk), .aresetn(aresetn), .pins({fc, fb, fa}), .meas_r(meas));

    initial begin
        forever #20 aclk = ~aclk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Cycles per one-LSB step: tenths of a second over 10 us ticks, 255 steps a sweep
    function automatic int step_cyc(input logic [2:0] c, input logic slow, input logic div4);
        return (slow ? slow_t[c] : fast_t[c]) * 10000 / 255 * (div4 ? 4 : 1) * TL;
    endfunction

    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Tick phase is unknown, so a ramp reading may be one step either side
    task automatic cmp_rng(input string what, input int lo, input int hi, input logic [7:0] got);
        compares++;
        if ((^got === 1'bx) || int'(got) < lo || int'(got) > hi) begin
            err_total++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge aclk);
        req.awaddr <= {2'b00, idx, 2'b00};
        req.awvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
        req.bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] idx);
        @(posedge aclk);
        req.araddr <= {2'b00, idx, 2'b00};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        rd = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
    endtask

    task automatic set_req(input logic [7:0] rq);
        @(posedge aclk);
        for (int i = 0; i < 3; i++) begin
            fan[i] <= '{1'b0, 1'b0, fpr_chan_t'(i[1:0]), 8'h00, rq};
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] a, b;
        logic [2:0] ca, cb, cc, dv;
        logic sl;
        logic [31:0] v;
        logic [2:0][7:0] ex;
        fpr_fan_in_t f;
        int w, e;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(IDX_RAMP_RATE_REMOTE1_A);
        cmp_val("ctrl_a reset", 32'h0, rd);
        rdr(IDX_RAMP_RATE_REMOTE1_B);
        cmp_val("ctrl_b reset", 32'h0, rd);
        rdr(8'h11);
        cmp_val("unmapped rresp", RESP_SLVERR, resp);
        wr(8'h11, 8'hff);
        cmp_val("unmapped bresp", RESP_SLVERR, resp);
        cmp_val("sync c d", 2'b11, {sc, sd});
        end_test("reset");
        for (int r = 0; r < 4; r++) begin
            ca = 3'(RT[r][0]);
            cb = 3'(RT[r][1]);
            cc = 3'(RT[r][2]);
            sl = 1'(RT[r][3]);
            dv = 3'(RT[r][4]);
            w = RT[r][5];
            wr(IDX_RAMP_CFG, {sl, 4'h0, dv});
            wr(IDX_RAMP_RATE_REMOTE1_A, {5'h0, ca});
            wr(IDX_RAMP_RATE_REMOTE1_B, {1'b0, cc, 1'b0, cb});
            set_req(8'h00);
            repeat (4) @(posedge aclk);
            rdr(IDX_DUTY_STAT);
            cmp_val("duty direct zero", 32'h0, rd);
            wr(IDX_RAMP_RATE_REMOTE1_A, {5'h1, ca});
            wr(IDX_RAMP_RATE_REMOTE1_B, {1'b1, cc, 1'b1, cb});
            set_req(8'hc8);
            repeat (w) @(posedge aclk);
            rdr(IDX_DUTY_STAT);
            e = w / step_cyc(ca, sl, dv[0]);
            cmp_rng("duty a ramp", e - 1, e + 1, rd[7:0]);
            e = w / step_cyc(cb, sl, dv[1]);
            cmp_rng("duty b ramp", e - 1, e + 1, rd[15:8]);
            e = w / step_cyc(cc, sl, dv[2]);
            cmp_rng("duty c ramp", e - 1, e + 1, rd[23:16]);
        end
        end_test("ramp");
        for (int k = 0; k < 6; k++) begin
            a = 8'(xs());
            a[3] = 1'b0;
            b = 8'(xs());
            b[3] = 1'b0;
            b[7] = 1'b0;
            wr(IDX_RAMP_RATE_REMOTE1_A, a);
            wr(IDX_RAMP_RATE_REMOTE1_B, b);
            rdr(IDX_RAMP_RATE_REMOTE1_A);
            cmp_val("ctrl_a readback", {24'h0, a}, rd);
            cmp_val("sync b", a[4], sb);
            @(posedge aclk);
            for (int i = 0; i < 3; i++) begin
                v = xs();
                f = v[$bits(fpr_fan_in_t)-1:0];
                // Odd rounds put every output below floor, so both floor choices are seen
                if (k[0]) begin
                    f.auto_mode = 1'b1;
                    f.below_floor = 1'b1;
                end
                fan[i] <= f;
                ex[i] = (f.auto_mode && f.below_floor) ? (a[5+i] ? f.min_duty : 8'h00)
                                                       : f.duty_req;
            end
            repeat (600) @(posedge aclk);
            rdr(IDX_DUTY_STAT);
            for (int i = 0; i < 3; i++) begin
                cmp_val("duty direct", ex[i], rd[8*i +: 8]);
                cmp_val("pin duty", ex[i], meas[i]);
            end
        end
        end_test("floor");
        wr(IDX_LOCK_CFG, 8'h01);
        wr(IDX_RAMP_RATE_REMOTE1_A, ~a);
        cmp_val("locked bresp", RESP_OKAY, resp);
        wr(IDX_RAMP_RATE_REMOTE1_B, ~b);
        rdr(IDX_RAMP_RATE_REMOTE1_A);
        cmp_val("locked ctrl_a", {24'h0, a}, rd);
        rdr(IDX_RAMP_RATE_REMOTE1_B);
        cmp_val("locked ctrl_b", {24'h0, b}, rd);
        end_test("lock");
        wrap_up();
    end

    // Tests need about 40000 cycles
    initial begin
        repeat (60000) @(posedge aclk);
        err_total++;
        wrap_up();
    end
endmodule // tb
